//--- shared/steer_pkg.sv
// Constants, types and helpers for the steering word distribution block
// Assumes one core clock; all users refer to names as steer_pkg::name
package steer_pkg;

  // ----------------------------------------------------------------
  // Widths and counts
  // ----------------------------------------------------------------
  localparam int STEER_W   = 32;
  localparam int FCW_W     = 36;
  localparam int N_TX      = 4;
  localparam int N_FOD     = 3;
  localparam int N_RX      = 4;
  localparam int INT_W     = 10;
  localparam int FRAC_W    = 38;
  localparam int NOM_W     = 48;
  localparam int RATIO_W   = 49;
  localparam int FCW_SHIFT = 44;
  localparam int N_IOD     = 12;
  localparam int N_XCONN   = 6;
  localparam int PDIV_W    = 8;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] A_CTRL       = 8'h00;
  localparam logic [7:0] A_PLL_OP     = 8'h04;
  localparam logic [7:0] A_DIV_OP     = 8'h08;
  localparam logic [7:0] A_FB_INT     = 8'h0c;
  localparam logic [7:0] A_FRAC_LO    = 8'h10;
  localparam logic [7:0] A_FRAC_HI    = 8'h14;
  localparam logic [7:0] A_OFFSET0    = 8'h18;
  localparam logic [7:0] A_WFREQ0     = 8'h28;
  localparam logic [7:0] A_POST_DIV   = 8'h34;
  localparam logic [7:0] A_XCONN      = 8'h38;
  localparam logic [7:0] A_STAT_FCW   = 8'h3c;
  localparam logic [7:0] A_STAT_RATIO = 8'h40;
  localparam logic [7:0] A_STAT_RHI   = 8'h44;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int CTRL_INT_MODE_BIT = 0;
  localparam int CTRL_HOLD_LSB     = 1;
  localparam logic [4:0]  RST_CTRL     = 5'h00;
  localparam logic [7:0]  RST_OP       = 8'h00;
  localparam logic [9:0]  RST_FB_INT   = 10'h000;
  localparam logic [37:0] RST_FRAC     = 38'h00_0000_0000;
  localparam logic [31:0] RST_WORD     = 32'h0000_0000;
  localparam logic [7:0]  RST_POST_DIV = 8'h00;
  localparam logic [5:0]  RST_XCONN    = 6'h00;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    OP_IGNORE = 2'b00,
    OP_ADD    = 2'b01,
    OP_SUB    = 2'b10
  } steer_op_t;

  typedef struct packed {
    logic [N_TX-1:0][STEER_W-1:0] word;
  } steer_words_t;

  // Byte-lane merge of a bus write into a stored word
  function automatic logic [31:0] be_merge(input logic [31:0] old,
                                           input logic [31:0] wdat,
                                           input logic [3:0]  be);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = wdat[i*8 +: 8];
      end
    end
    return res;
  endfunction

endpackage

//--- src/steer_receiver.sv
// One steering bus receiver: selects, sums and offsets steering words
// Assumes steering words and settings come from logic on clk
`timescale 1ns/1ps
module steer_receiver #(
  parameter int STEER_W = 32,
  parameter int FCW_W   = 36,
  parameter int N_TX    = 4
) (
  input  wire logic                              clk,
  input  wire logic                              nrst,
  input  wire logic [N_TX-1:0][STEER_W-1:0]      words,
  input  wire logic [2*N_TX-1:0]                 op_sel,
  input  wire logic [STEER_W-1:0]                offset,
  input  wire logic                              hold,
  output logic signed [FCW_W-1:0]                frequency_control_word
);

  // ----------------------------------------------------------------
  // Selection and sum
  // ----------------------------------------------------------------
  function automatic logic signed [FCW_W-1:0] op_term(
      input logic [1:0] op, input logic [STEER_W-1:0] w);
    logic signed [FCW_W-1:0] ext;
    ext = FCW_W'($signed(w));
    case (op)
      steer_pkg::OP_ADD: return ext;
      steer_pkg::OP_SUB: return -ext;
      default:           return '0;
    endcase
  endfunction

  logic signed [FCW_W-1:0] sum;
  logic signed [FCW_W-1:0] next_sum;

  always_comb begin
    next_sum = '0;
    for (int t = 0; t < N_TX; t++) begin
      next_sum = next_sum + op_term(op_sel[2*t +: 2], words[t]);
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sum <= '0;
    end else if (!hold) begin
      sum <= next_sum;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      frequency_control_word <= '0;
    end else begin
      frequency_control_word <= FCW_W'($signed(offset)) + sum;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_hold_freeze;
    @(posedge clk) disable iff (!nrst)
      hold |=> $stable(sum);
  endproperty
  a_hold_freeze: assert property (p_hold_freeze)
    else $error("steering sum moved while held");

  property p_ignore_all;
    @(posedge clk) disable iff (!nrst)
      (!hold && op_sel == '0) ##1 $stable(offset) |=>
        frequency_control_word == FCW_W'($signed($past(offset)));
  endproperty
  a_ignore_all: assert property (p_ignore_all)
    else $error("ignored words changed the control word");

endmodule

//--- src/post_divider.sv
// Oscillator post-divider and its distribution to integer dividers
// Assumes the divide setting is a register on clk
`timescale 1ns/1ps
module post_divider #(
  parameter int PDIV_W  = 8,
  parameter int N_IOD   = 12,
  parameter int N_XCONN = 6
) (
  input  wire logic               clk,
  input  wire logic               nrst,
  input  wire logic [PDIV_W-1:0]  div_val,
  input  wire logic [N_XCONN-1:0] xconn_en,
  output logic [N_IOD-1:0]        iod_src
);

  logic [PDIV_W-1:0] cnt;
  logic              div_clk;

  // Toggles every div_val+1 cycles
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt     <= '0;
      div_clk <= 1'b0;
    end else if (cnt >= div_val) begin
      cnt     <= '0;
      div_clk <= ~div_clk;
    end else begin
      cnt <= cnt + PDIV_W'(1);
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      iod_src <= '0;
    end else begin
      iod_src[N_XCONN-1:0]     <= {N_XCONN{div_clk}};
      iod_src[N_IOD-1:N_XCONN] <= {N_XCONN{div_clk}} & xconn_en;
    end
  end

  property p_xconn_off;
    @(posedge clk) disable iff (!nrst)
      (xconn_en == '0) |=> iod_src[N_IOD-1:N_XCONN] == '0;
  endproperty
  a_xconn_off: assert property (p_xconn_off)
    else $error("cross-connected divider fed while disabled");

endmodule

//--- src/steer_dist.sv
// Steering word distribution top with Avalon-MM register slave
// Assumes transmitter words arrive on clk from on-chip logic
//
// Our own choices: register access over Avalon-MM and the address map.
`timescale 1ns/1ps
module steer_dist #(
  parameter int STEER_W = steer_pkg::STEER_W,
  parameter int FCW_W   = steer_pkg::FCW_W
) (
  input  wire logic                             clk,
  input  wire logic                             nrst,
  input  wire logic [7:0]                       address,
  input  wire logic                             read,
  input  wire logic                             write,
  input  wire logic [31:0]                      writedata,
  input  wire logic [3:0]                       byteenable,
  output logic [31:0]                           readdata,
  output logic                                  waitrequest,
  input  wire steer_pkg::steer_words_t          steer_in,
  output logic signed [FCW_W-1:0]               pll_fcw,
  output logic [steer_pkg::N_FOD-1:0][FCW_W-1:0] fod_fcw,
  output logic [steer_pkg::RATIO_W-1:0]         pll_feedback_ratio,
  output logic [steer_pkg::N_IOD-1:0]           iod_src
);

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  logic [4:0]                            ctrl;
  logic [7:0]                            pll_receiver_op_select;
  logic [steer_pkg::N_FOD-1:0][7:0]      divider_receiver_op_select;
  logic [steer_pkg::INT_W-1:0]           pll_feedback_integer;
  logic [steer_pkg::FRAC_W-1:0]          pll_feedback_fraction;
  logic [steer_pkg::N_RX-1:0][31:0]      combo_offset;
  logic [steer_pkg::N_FOD-1:0][31:0]     fod_write_word;
  logic [steer_pkg::PDIV_W-1:0]          post_div;
  logic [steer_pkg::N_XCONN-1:0]         xconn_en;

  logic       integer_mode;
  logic [3:0] sum_hold;
  logic       wr_ok;
  logic [7:0] idx_off;

  assign integer_mode = ctrl[steer_pkg::CTRL_INT_MODE_BIT];
  assign sum_hold     = ctrl[steer_pkg::CTRL_HOLD_LSB +: 4];
  assign wr_ok        = write && !waitrequest;
  assign idx_off      = address - steer_pkg::A_OFFSET0;

  // ----------------------------------------------------------------
  // Bus handshake
  // ----------------------------------------------------------------
  // One wait cycle, then one ready cycle per request
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      waitrequest <= 1'b1;
    end else if (!waitrequest) begin
      waitrequest <= 1'b1;
    end else if (read || write) begin
      waitrequest <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctrl                       <= steer_pkg::RST_CTRL;
      pll_receiver_op_select     <= steer_pkg::RST_OP;
      divider_receiver_op_select <= '0;
      pll_feedback_integer       <= steer_pkg::RST_FB_INT;
      pll_feedback_fraction      <= steer_pkg::RST_FRAC;
      combo_offset               <= '0;
      fod_write_word             <= '0;
      post_div                   <= steer_pkg::RST_POST_DIV;
      xconn_en                   <= steer_pkg::RST_XCONN;
    end else if (wr_ok) begin
      if (address == steer_pkg::A_CTRL) begin
        ctrl <= 5'(steer_pkg::be_merge(32'(ctrl), writedata, byteenable));
      end else if (address == steer_pkg::A_PLL_OP) begin
        pll_receiver_op_select <= 8'(steer_pkg::be_merge(
          32'(pll_receiver_op_select), writedata, byteenable));
      end else if (address == steer_pkg::A_DIV_OP) begin
        divider_receiver_op_select <= 24'(steer_pkg::be_merge(
          32'(divider_receiver_op_select), writedata, byteenable));
      end else if (address == steer_pkg::A_FB_INT) begin
        pll_feedback_integer <= 10'(steer_pkg::be_merge(
          32'(pll_feedback_integer), writedata, byteenable));
      end else if (address == steer_pkg::A_FRAC_LO) begin
        pll_feedback_fraction[31:0] <= steer_pkg::be_merge(
          pll_feedback_fraction[31:0], writedata, byteenable);
      end else if (address == steer_pkg::A_FRAC_HI) begin
        pll_feedback_fraction[37:32] <= 6'(steer_pkg::be_merge(
          32'(pll_feedback_fraction[37:32]), writedata, byteenable));
      end else if (address >= steer_pkg::A_OFFSET0 &&
                   address <  steer_pkg::A_WFREQ0) begin
        combo_offset[idx_off[3:2]] <= steer_pkg::be_merge(
          combo_offset[idx_off[3:2]], writedata, byteenable);
      end else if (address == steer_pkg::A_WFREQ0) begin
        fod_write_word[0] <= steer_pkg::be_merge(
          fod_write_word[0], writedata, byteenable);
      end else if (address == steer_pkg::A_WFREQ0 + 8'h04) begin
        fod_write_word[1] <= steer_pkg::be_merge(
          fod_write_word[1], writedata, byteenable);
      end else if (address == steer_pkg::A_WFREQ0 + 8'h08) begin
        fod_write_word[2] <= steer_pkg::be_merge(
          fod_write_word[2], writedata, byteenable);
      end else if (address == steer_pkg::A_POST_DIV) begin
        post_div <= 8'(steer_pkg::be_merge(
          32'(post_div), writedata, byteenable));
      end else if (address == steer_pkg::A_XCONN) begin
        xconn_en <= 6'(steer_pkg::be_merge(
          32'(xconn_en), writedata, byteenable));
      end
    end
  end

  // ----------------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------------
  logic [31:0] next_readdata;

  always_comb begin
    next_readdata = 32'h0000_0000;
    if (address == steer_pkg::A_CTRL) begin
      next_readdata = 32'(ctrl);
    end else if (address == steer_pkg::A_PLL_OP) begin
      next_readdata = 32'(pll_receiver_op_select);
    end else if (address == steer_pkg::A_DIV_OP) begin
      next_readdata = 32'(divider_receiver_op_select);
    end else if (address == steer_pkg::A_FB_INT) begin
      next_readdata = 32'(pll_feedback_integer);
    end else if (address == steer_pkg::A_FRAC_LO) begin
      next_readdata = pll_feedback_fraction[31:0];
    end else if (address == steer_pkg::A_FRAC_HI) begin
      next_readdata = 32'(pll_feedback_fraction[37:32]);
    end else if (address >= steer_pkg::A_OFFSET0 &&
                 address <  steer_pkg::A_WFREQ0) begin
      next_readdata = combo_offset[idx_off[3:2]];
    end else if (address == steer_pkg::A_WFREQ0) begin
      next_readdata = fod_write_word[0];
    end else if (address == steer_pkg::A_WFREQ0 + 8'h04) begin
      next_readdata = fod_write_word[1];
    end else if (address == steer_pkg::A_WFREQ0 + 8'h08) begin
      next_readdata = fod_write_word[2];
    end else if (address == steer_pkg::A_POST_DIV) begin
      next_readdata = 32'(post_div);
    end else if (address == steer_pkg::A_XCONN) begin
      next_readdata = 32'(xconn_en);
    end else if (address == steer_pkg::A_STAT_FCW) begin
      next_readdata = pll_fcw[31:0];
    end else if (address == steer_pkg::A_STAT_RATIO) begin
      next_readdata = pll_feedback_ratio[31:0];
    end else if (address == steer_pkg::A_STAT_RHI) begin
      next_readdata = 32'(pll_feedback_ratio[48:32]);
    end
  end

  // Data captured when the request is first seen
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      readdata <= 32'h0000_0000;
    end else if (read && waitrequest) begin
      readdata <= next_readdata;
    end
  end

  // ----------------------------------------------------------------
  // Receivers
  // ----------------------------------------------------------------
  logic signed [FCW_W-1:0]                  pll_rx_fcw;
  logic [steer_pkg::N_FOD-1:0][FCW_W-1:0]   fod_rx_fcw;

  steer_receiver #(
    .STEER_W (STEER_W),
    .FCW_W   (FCW_W),
    .N_TX    (steer_pkg::N_TX)
  ) u_pll_rx (
    .clk    (clk),
    .nrst   (nrst),
    .words  (steer_in.word),
    .op_sel (pll_receiver_op_select),
    .offset (combo_offset[0]),
    .hold   (sum_hold[0]),
    .frequency_control_word    (pll_rx_fcw)
  );

  for (genvar f = 0; f < steer_pkg::N_FOD; f++) begin : g_fod_rx
    logic signed [FCW_W-1:0] rx_fcw;
    steer_receiver #(
      .STEER_W (STEER_W),
      .FCW_W   (FCW_W),
      .N_TX    (steer_pkg::N_TX)
    ) u_rx (
      .clk    (clk),
      .nrst   (nrst),
      .words  (steer_in.word),
      .op_sel (divider_receiver_op_select[f]),
      .offset (combo_offset[f+1]),
      .hold   (sum_hold[f+1]),
      .frequency_control_word    (rx_fcw)
    );
    assign fod_rx_fcw[f] = rx_fcw;
  end

  // ----------------------------------------------------------------
  // Control word outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pll_fcw <= '0;
      fod_fcw <= '0;
    end else begin
      pll_fcw <= integer_mode ? '0 : pll_rx_fcw;
      for (int f = 0; f < steer_pkg::N_FOD; f++) begin
        fod_fcw[f] <= fod_rx_fcw[f] +
                      FCW_W'($signed(fod_write_word[f]));
      end
    end
  end

  // ----------------------------------------------------------------
  // Pll feedback ratio
  // ----------------------------------------------------------------
  logic [steer_pkg::NOM_W-1:0] nominal;
  logic signed [84:0]          product;
  logic signed [49:0]          steered;

  always_comb begin
    if (integer_mode) begin
      nominal = {pll_feedback_integer, {steer_pkg::FRAC_W{1'b0}}};
    end else begin
      nominal = {pll_feedback_integer, pll_feedback_fraction};
    end
    product = $signed({1'b0, nominal}) * 85'(pll_fcw);
    steered = $signed({2'b00, nominal}) +
              {{9{product[84]}}, product[84:steer_pkg::FCW_SHIFT]};
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pll_feedback_ratio <= '0;
    end else begin
      pll_feedback_ratio <= steered[steer_pkg::RATIO_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Post-divider
  // ----------------------------------------------------------------
  post_divider #(
    .PDIV_W  (steer_pkg::PDIV_W),
    .N_IOD   (steer_pkg::N_IOD),
    .N_XCONN (steer_pkg::N_XCONN)
  ) u_post_div (
    .clk      (clk),
    .nrst     (nrst),
    .div_val  (post_div),
    .xconn_en (xconn_en),
    .iod_src  (iod_src)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_wait_one;
    @(posedge clk) disable iff (!nrst)
      !waitrequest |=> waitrequest;
  endproperty
  a_wait_one: assert property (p_wait_one)
    else $error("waitrequest low for more than one cycle");

  property p_answer;
    @(posedge clk) disable iff (!nrst)
      (read || write) && waitrequest |=> !waitrequest;
  endproperty
  a_answer: assert property (p_answer)
    else $error("request not answered after one cycle");

  property p_int_mode;
    @(posedge clk) disable iff (!nrst)
      integer_mode ##1 integer_mode |=>
        pll_feedback_ratio[37:0] == '0 && pll_fcw == '0;
  endproperty
  a_int_mode: assert property (p_int_mode)
    else $error("integer mode still steered or fractional");

  property p_nominal;
    @(posedge clk) disable iff (!nrst)
      (!integer_mode && pll_fcw == '0) |=> pll_feedback_ratio ==
        {1'b0, $past(pll_feedback_integer), $past(pll_feedback_fraction)};
  endproperty
  a_nominal: assert property (p_nominal)
    else $error("unsteered ratio differs from nominal");

  property p_direct_write;
    @(posedge clk) disable iff (!nrst)
      1'b1 |=> fod_fcw[0] == $past(fod_rx_fcw[0]) +
        FCW_W'($signed($past(fod_write_word[0])));
  endproperty
  a_direct_write: assert property (p_direct_write)
    else $error("divider word lost its direct write term");

  property p_steer_up;
    @(posedge clk) disable iff (!nrst)
      (!integer_mode && pll_fcw > 0 && nominal != '0) |=>
        pll_feedback_ratio >= {1'b0, $past(nominal)};
  endproperty
  a_steer_up: assert property (p_steer_up)
    else $error("positive control word lowered the ratio");

  property p_wait_idle;
    @(posedge clk) disable iff (!nrst)
      !read && !write && waitrequest |=> waitrequest;
  endproperty
  a_wait_idle: assert property (p_wait_idle)
    else $error("waitrequest dropped without a request");

  property p_pll_word;
    @(posedge clk) disable iff (!nrst)
      !integer_mode |=> pll_fcw == $past(pll_rx_fcw);
  endproperty
  a_pll_word: assert property (p_pll_word)
    else $error("pll control word differs from its receiver");

  property p_read_data;
    @(posedge clk) disable iff (!nrst)
      read && waitrequest |=> readdata == $past(next_readdata);
  endproperty
  a_read_data: assert property (p_read_data)
    else $error("read data not taken from the addressed register");

endmodule

//--- tb/steer_tx_model.sv
// Transmitter side model: four registered steering words
// Assumes the bench sets the words on the rising edge of clk
`timescale 1ns/1ps
module steer_tx_model (
  input  wire logic               clk,
  input  wire logic               nrst,
  input  wire logic [3:0][31:0]   word_set,
  output steer_pkg::steer_words_t steer_out
);
  // ------------------------------------------------------------
  // Word registers
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      steer_out <= '0;
    end else begin
      steer_out.word <= word_set;
    end
  end
endmodule

//--- tb/steer_dist_tb.sv
// Self-checking bench for the steering distribution block
// Assumes the design package and the transmitter model are compiled
`timescale 1ns/1ps
module steer_dist_tb;
  logic                    clk = 1'b0;
  logic                    nrst = 1'b0;
  logic [7:0]              address = 8'h00;
  logic                    read = 1'b0;
  logic                    write = 1'b0;
  logic [31:0]             writedata = 32'h0000_0000;
  logic [3:0]              byteenable = 4'hf;
  logic [31:0]             readdata;
  logic                    waitrequest;
  logic [3:0][31:0]        word_set = '0;
  steer_pkg::steer_words_t steer_in;
  logic signed [35:0]      pll_fcw;
  logic [2:0][35:0]        fod_fcw;
  logic [48:0]             ratio;
  logic [11:0]             iod_src;
  logic [31:0]             rd;
  logic [35:0]             e;
  logic                    prev;
  int                      bad_count = 0;
  int                      total_checks = 0;
  int                      tog;

  always #5 clk = ~clk;

  steer_tx_model tx (.clk(clk), .nrst(nrst), .word_set(word_set),
                     .steer_out(steer_in));
  steer_dist dut (.clk(clk), .nrst(nrst), .address(address), .read(read),
                  .write(write), .writedata(writedata),
                  .byteenable(byteenable), .readdata(readdata),
                  .waitrequest(waitrequest), .steer_in(steer_in),
                  .pll_fcw(pll_fcw), .fod_fcw(fod_fcw),
                  .pll_feedback_ratio(ratio), .iod_src(iod_src));

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic [3:0] be);
    int n;
    n = 0;
    @(posedge clk);
    address <= a;
    writedata <= d;
    byteenable <= be;
    read <= !w;
    write <= w;
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 20);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
    if (waitrequest !== 1'b0) begin
      bad_count++;
      $display("unexpected at %0t: bus timeout", $time);
      finish_test();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 4'hf);
  endtask

  task automatic chk_reg(input logic [7:0] a, input logic [31:0] x);
    bus(1'b0, a, 32'h0000_0000, 4'hf);
    total_checks++;
    if (rd !== x) begin
      bad_count++;
      $display("unexpected at %0t: reg %h got %h want %h", $time, a, rd, x);
    end
  endtask

  task automatic chk_word(input logic [48:0] got, input logic [48:0] x);
    total_checks++;
    if (got !== x) begin
      bad_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, x);
    end
  endtask

  task automatic settle();
    repeat (8) @(posedge clk);
  endtask

  // Expected word from op codes, offset and direct word
  function automatic logic [35:0] model(input logic [7:0] op,
                                        input logic [31:0] off,
                                        input logic [31:0] dw);
    logic signed [35:0] s;
    s = 36'($signed(off)) + 36'($signed(dw));
    for (int t = 0; t < 4; t++) begin
      if (op[2*t +: 2] == 2'b01) begin
        s = s + 36'($signed(word_set[t]));
      end else if (op[2*t +: 2] == 2'b10) begin
        s = s - 36'($signed(word_set[t]));
      end
    end
    return s;
  endfunction

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    for (int a = 0; a <= 8'h44; a += 4) begin
      chk_reg(8'(a), 32'h0000_0000);
    end
    chk_reg(8'hfc, 32'h0000_0000);
    $display("reset test done");
    wr(steer_pkg::A_PLL_OP, 32'h0000_0001);
    wr(steer_pkg::A_DIV_OP, 32'h0012_0642);
    wr(steer_pkg::A_OFFSET0, 32'h0000_0100);
    wr(8'h1c, 32'hffff_fff0);
    wr(8'h20, 32'h0000_0020);
    wr(steer_pkg::A_WFREQ0, 32'h0000_0005);
    word_set <= {32'h0000_0007, 32'hffff_ffb0, 32'h0000_1000, 32'h0000_0300};
    settle();
    chk_word(49'(pll_fcw), 49'(model(8'h01, 32'h100, 0)));
    chk_word(49'(fod_fcw[0]), 49'(model(8'h42, 32'hffff_fff0, 5)));
    chk_word(49'(fod_fcw[1]), 49'(model(8'h06, 32'h20, 0)));
    bus(1'b1, steer_pkg::A_DIV_OP, 32'h00e4_0000, 4'b0100);
    chk_reg(steer_pkg::A_DIV_OP, 32'h00e4_0642);
    settle();
    chk_word(49'(fod_fcw[2]), 49'(model(8'he4, 0, 0)));
    $display("combine test done");
    wr(steer_pkg::A_FB_INT, 32'h0000_0010);
    wr(steer_pkg::A_FRAC_LO, 32'h0000_0001);
    settle();
    // Nominal 2^42 + 1 with word 0x400 adds 0x100
    chk_word(ratio, 49'h400_0000_0101);
    chk_reg(steer_pkg::A_STAT_RATIO, 32'h0000_0101);
    chk_reg(steer_pkg::A_STAT_RHI, 32'h0000_0400);
    chk_reg(steer_pkg::A_STAT_FCW, 32'h0000_0400);
    wr(steer_pkg::A_CTRL, 32'h0000_0001);
    settle();
    chk_word(49'(pll_fcw), 49'h0);
    chk_word(ratio, 49'h400_0000_0000);
    $display("ratio test done");
    wr(steer_pkg::A_CTRL, 32'h0000_0002);
    e = model(8'h01, 32'h200, 0);
    word_set[0] <= 32'h0000_0700;
    wr(steer_pkg::A_OFFSET0, 32'h0000_0200);
    settle();
    chk_word(49'(pll_fcw), 49'(e));
    chk_word(49'(fod_fcw[0]), 49'(model(8'h42, 32'hffff_fff0, 5)));
    wr(steer_pkg::A_CTRL, 32'h0000_0000);
    settle();
    chk_word(49'(pll_fcw), 49'(model(8'h01, 32'h200, 0)));
    $display("hold test done");
    wr(steer_pkg::A_POST_DIV, 32'h0000_0001);
    settle();
    tog = 0;
    prev = iod_src[0];
    repeat (20) begin
      @(posedge clk);
      if (iod_src[0] !== prev) begin
        tog++;
      end
      prev = iod_src[0];
    end
    chk_word(49'(tog), 49'd10);
    chk_word(49'(iod_src[11:6]), 49'h0);
    wr(steer_pkg::A_XCONN, 32'h0000_003f);
    settle();
    chk_word(49'(iod_src[11:6]), 49'(iod_src[5:0]));
    tog = 0;
    prev = iod_src[6];
    repeat (20) begin
      @(posedge clk);
      if (iod_src[6] !== prev) begin
        tog++;
      end
      prev = iod_src[6];
    end
    chk_word(49'(tog), 49'd10);
    $display("divider test done");
    finish_test();
  end
endmodule
